// ==== common/riqc_pkg.sv ====
/*
 package for the reference input qualify configuration block: register indices,
 field positions, reset values, timing constants and carrier structs.
 assumes a 125 mhz core clock.
*/
package riqc_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_SETUP = 8'h0a;
	localparam logic [7:0] IDX_DISQ = 8'h0b;
	localparam logic [7:0] IDX_QUAL = 8'h0c;
	localparam logic [7:0] IDX_FREEZE = 8'h0d;
	localparam logic [7:0] IDX_RATE_HI = 8'h10;
	localparam logic [7:0] IDX_RATE_LO = 8'h11;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h20;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
	localparam logic [7:0] IDX_QSTATE = 8'h22;

	localparam logic [7:0] RST_SETUP = 8'h10;
	localparam logic [7:0] RST_DISQ = 8'haa;
	localparam logic [7:0] RST_QUAL = 8'h55;
	localparam logic [7:0] RST_FREEZE = 8'h00;
	localparam logic [15:0] RST_RATE = 16'h9c40;
	localparam logic [7:0] FREEZE_ON = 8'h01;
	localparam logic [7:0] FREEZE_OFF = 8'h00;

	// setup field positions
	localparam int SETUP_HALF_A = 0;
	localparam int SETUP_HALF_B = 1;
	localparam int SETUP_DIFF_A = 4;
	localparam int SETUP_DIFF_B = 5;
	localparam int SEL_W = 2;

	// disqualify delay selections
	localparam logic [1:0] SEL_MIN = 2'h0;
	localparam logic [1:0] SEL_10MS = 2'h1;
	localparam logic [1:0] SEL_50MS = 2'h2;
	localparam logic [1:0] SEL_2S5 = 2'h3;

	// qualify multiples of the disqualify delay
	localparam logic [3:0] MULT_00 = 4'h2;
	localparam logic [3:0] MULT_01 = 4'h4;
	localparam logic [3:0] MULT_10 = 4'h6;
	localparam logic [3:0] MULT_11 = 4'h8;

	// times in microseconds, clock in mhz
	localparam int CLK_MHZ = 125;
	localparam int T_10MS_US = 10000;
	localparam int T_50MS_US = 50000;
	localparam int T_2S5_US = 2500000;
	localparam int C_10MS = T_10MS_US * CLK_MHZ;
	localparam int C_50MS = T_50MS_US * CLK_MHZ;
	localparam int C_2S5 = T_2S5_US * CLK_MHZ;
	localparam int CNT_W = 32;

	// irq status bit layout
	localparam int EV_SOAK_A = 0;
	localparam int EV_SOAK_B = 1;
	localparam int EV_QUAL_A = 2;
	localparam int EV_QUAL_B = 3;
	localparam int EV_W = 4;

	typedef struct packed {
		logic [1:0] fail_cfm;
		logic [1:0] fail_scm;
	} riqc_mon_t;

	typedef struct packed {
		logic [1:0] halving_enable;
		logic [1:0] differential_select;
		logic [1:0] qualified;
		logic [1:0] soak_expired_flag;
		logic freeze;
		logic [15:0] base_rate_value;
	} riqc_cfg_t;

	typedef enum logic [1:0] {
		Q_OK = 2'b00,
		Q_DISQ_WAIT = 2'b01,
		Q_FAILED = 2'b11,
		Q_QUAL_WAIT = 2'b10
	} riqc_qstate_t;
endpackage

// ==== rtl/riqc_config.sv ====
/*
 reference input qualify configuration: avalon-mm register slave, per-reference
 halving dividers and input select, guard soak timers with irq status.
 assumes monitor indicators and reference pins are asynchronous to core_clk.
*/
`timescale 1ns/1ps
module riqc_config
	import riqc_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [1:0] ref_positive_pin,
	input wire logic [1:0] ref_negative_pin,
	input wire riqc_pkg::riqc_mon_t mon_in,
	output logic [1:0] pll_ref_clk,
	output riqc_pkg::riqc_cfg_t cfg_out,
	output logic irq
);
	import riqc_pkg::*;

	logic [7:0] setup, next_setup;
	logic [7:0] disq, next_disq;
	logic [7:0] qual, next_qual;
	logic [7:0] freeze, next_freeze;
	logic [15:0] rate, next_rate;
	logic [EV_W-1:0] stat, next_stat;
	logic [EV_W-1:0] mask, next_mask;
	logic [31:0] rdata, next_rdata;
	logic ack, next_ack;
	logic [1:0] soak_flag, next_soak_flag;
	logic [2:0] sy_p0, sy_p1, sy_n0, sy_n1, sy_c0, sy_c1, sy_s0, sy_s1;
	logic [2:0] next_sy_p0, next_sy_p1, next_sy_n0, next_sy_n1;
	logic [2:0] next_sy_c0, next_sy_c1, next_sy_s0, next_sy_s1;
	logic [1:0] in_lvl, next_in_lvl;
	logic [1:0] fail_lvl, next_fail_lvl;
	logic [1:0] in_prev, next_in_prev;
	logic [1:0] half_tgl, next_half_tgl;
	logic [1:0] ref_out, next_ref_out;
	riqc_qstate_t qst [2], next_qst [2];
	logic [CNT_W-1:0] cnt [2], next_cnt [2];
	logic [EV_W-1:0] ev;
	logic [7:0] idx;
	logic hit;

	// cycles of the selected disqualify delay; minimum is one cycle
	function automatic logic [CNT_W-1:0] disq_cycles(input logic [1:0] sel);
		case (sel)
			SEL_10MS: disq_cycles = CNT_W'(C_10MS);
			SEL_50MS: disq_cycles = CNT_W'(C_50MS);
			SEL_2S5: disq_cycles = CNT_W'(C_2S5);
			default: disq_cycles = CNT_W'(1);
		endcase
	endfunction

	// qualify cycles as a multiple of the disqualify delay
	function automatic logic [CNT_W-1:0] qual_cycles(input logic [1:0] dsel,
		input logic [1:0] qsel);
		logic [3:0] m;
		m = MULT_00;
		case (qsel)
			2'h1: m = MULT_01;
			2'h2: m = MULT_10;
			2'h3: m = MULT_11;
			default: m = MULT_00;
		endcase
		qual_cycles = CNT_W'(disq_cycles(dsel) * m);
	endfunction

	// a three-stage chain; a change counts when stages two and three agree
	function automatic logic filt(input logic [2:0] sy, input logic prev);
		filt = (sy[1] == sy[2]) ? sy[2] : prev;
	endfunction

	// register index from the byte address
	assign idx = avs_address[9:2];
	assign hit = (avs_read || avs_write) && !ack;

	// register writes, readback and sticky status
	always_comb
	begin
		next_setup = setup;
		next_disq = disq;
		next_qual = qual;
		next_freeze = freeze;
		next_rate = rate;
		next_mask = mask;
		next_rdata = rdata;
		next_ack = hit;
		next_stat = stat;
		if (avs_write && ack) // lands at the edge where waitrequest is low
		begin
			case (idx)
				// reserved bits keep their reset values
				IDX_SETUP: next_setup = (avs_writedata[7:0] & 8'h33) | (RST_SETUP & 8'hcc);
				IDX_DISQ: next_disq = {RST_DISQ[7:4], avs_writedata[3:0]};
				IDX_QUAL: next_qual = {RST_QUAL[7:4], avs_writedata[3:0]};
				IDX_FREEZE: next_freeze = avs_writedata[7:0];
				IDX_RATE_HI: next_rate = {avs_writedata[7:0], rate[7:0]};
				IDX_RATE_LO: next_rate = {rate[15:8], avs_writedata[7:0]};
				IDX_IRQ_MASK: next_mask = avs_writedata[EV_W-1:0];
				default: next_mask = mask;
			endcase
		end
		if (hit && avs_read)
		begin
			case (idx)
				IDX_SETUP: next_rdata = {24'h000000, setup};
				IDX_DISQ: next_rdata = {24'h000000, disq};
				IDX_QUAL: next_rdata = {24'h000000, qual};
				IDX_FREEZE: next_rdata = {24'h000000, freeze};
				IDX_RATE_HI: next_rdata = {24'h000000, rate[15:8]};
				IDX_RATE_LO: next_rdata = {24'h000000, rate[7:0]};
				IDX_IRQ_STAT: next_rdata = {28'h0000000, stat};
				IDX_IRQ_MASK: next_rdata = {28'h0000000, mask};
				IDX_QSTATE: next_rdata = {24'h000000, qst[1], qst[0], 2'h0, soak_flag};
				default: next_rdata = 32'h00000000;
			endcase
			if (idx == IDX_IRQ_STAT)
				next_stat = '0;
		end
		// a new event wins over the read clear; freeze keeps new events out of the sticky bits
		if (freeze != FREEZE_ON)
			next_stat = next_stat | ev;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			setup <= RST_SETUP;
			disq <= RST_DISQ;
			qual <= RST_QUAL;
			freeze <= RST_FREEZE;
			rate <= RST_RATE;
			mask <= '0;
			stat <= '0;
			rdata <= '0;
			ack <= 1'b0;
		end
		else
		begin
			setup <= next_setup;
			disq <= next_disq;
			qual <= next_qual;
			freeze <= next_freeze;
			rate <= next_rate;
			mask <= next_mask;
			stat <= next_stat;
			rdata <= next_rdata;
			ack <= next_ack;
		end
	end

	// one wait cycle per access; readdata registered
	assign avs_waitrequest = (avs_read || avs_write) && !ack;
	assign avs_readdata = rdata;
	assign irq = |(stat & mask);

	// synchronisers and input selection, halving divider
	always_comb
	begin
		logic [1:0] sel_in;
		sel_in = '0;
		next_sy_p0 = {sy_p0[1:0], ref_positive_pin[0]};
		next_sy_p1 = {sy_p1[1:0], ref_positive_pin[1]};
		next_sy_n0 = {sy_n0[1:0], ref_negative_pin[0]};
		next_sy_n1 = {sy_n1[1:0], ref_negative_pin[1]};
		next_sy_c0 = {sy_c0[1:0], mon_in.fail_cfm[0]};
		next_sy_c1 = {sy_c1[1:0], mon_in.fail_cfm[1]};
		next_sy_s0 = {sy_s0[1:0], mon_in.fail_scm[0]};
		next_sy_s1 = {sy_s1[1:0], mon_in.fail_scm[1]};
		sel_in[0] = setup[SETUP_DIFF_A]
			? (filt(sy_p0, in_lvl[0]) & ~filt(sy_n0, in_lvl[0])) | (in_lvl[0]
			& filt(sy_p0, 1'b1) == filt(sy_n0, 1'b1))
			: filt(sy_p0, in_lvl[0]);
		sel_in[1] = setup[SETUP_DIFF_B]
			? (filt(sy_p1, in_lvl[1]) & ~filt(sy_n1, in_lvl[1])) | (in_lvl[1]
			& filt(sy_p1, 1'b1) == filt(sy_n1, 1'b1))
			: filt(sy_p1, in_lvl[1]);
		next_in_lvl = sel_in;
		next_fail_lvl[0] = filt(sy_c0, fail_lvl[0]) | filt(sy_s0, fail_lvl[0]);
		next_fail_lvl[1] = filt(sy_c1, fail_lvl[1]) | filt(sy_s1, fail_lvl[1]);
		next_in_prev = in_lvl;
		next_half_tgl = half_tgl ^ (in_lvl & ~in_prev);
		next_ref_out[0] = setup[SETUP_HALF_A] ? half_tgl[0] : in_lvl[0];
		next_ref_out[1] = setup[SETUP_HALF_B] ? half_tgl[1] : in_lvl[1];
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			sy_p0 <= '0;
			sy_p1 <= '0;
			sy_n0 <= '0;
			sy_n1 <= '0;
			sy_c0 <= '0;
			sy_c1 <= '0;
			sy_s0 <= '0;
			sy_s1 <= '0;
			in_lvl <= '0;
			fail_lvl <= '0;
			in_prev <= '0;
			half_tgl <= '0;
			ref_out <= '0;
		end
		else
		begin
			sy_p0 <= next_sy_p0;
			sy_p1 <= next_sy_p1;
			sy_n0 <= next_sy_n0;
			sy_n1 <= next_sy_n1;
			sy_c0 <= next_sy_c0;
			sy_c1 <= next_sy_c1;
			sy_s0 <= next_sy_s0;
			sy_s1 <= next_sy_s1;
			in_lvl <= next_in_lvl;
			fail_lvl <= next_fail_lvl;
			in_prev <= next_in_prev;
			half_tgl <= next_half_tgl;
			ref_out <= next_ref_out;
		end
	end

	// guard soak timers, one per reference
	always_comb
	begin
		ev = '0;
		next_soak_flag = soak_flag;
		for (int r = 0; r < 2; r++)
		begin
			logic [1:0] dsel;
			logic [1:0] qsel;
			dsel = disq[SEL_W*r +: SEL_W];
			qsel = qual[SEL_W*r +: SEL_W];
			next_qst[r] = qst[r];
			next_cnt[r] = cnt[r];
			case (qst[r])
				Q_OK:
					if (fail_lvl[r])
					begin
						next_qst[r] = Q_DISQ_WAIT;
						next_cnt[r] = disq_cycles(dsel) - CNT_W'(1);
					end
				Q_DISQ_WAIT:
					if (!fail_lvl[r])
						next_qst[r] = Q_OK;
					else if (cnt[r] == '0)
					begin
						next_qst[r] = Q_FAILED;
						next_soak_flag[r] = 1'b1;
						ev[EV_SOAK_A + r] = 1'b1;
					end
					else
						next_cnt[r] = cnt[r] - CNT_W'(1);
				Q_FAILED:
					if (!fail_lvl[r])
					begin
						next_qst[r] = Q_QUAL_WAIT;
						next_cnt[r] = qual_cycles(dsel, qsel) - CNT_W'(1);
					end
				Q_QUAL_WAIT:
					if (fail_lvl[r])
						next_qst[r] = Q_FAILED;
					else if (cnt[r] == '0)
					begin
						next_qst[r] = Q_OK;
						next_soak_flag[r] = 1'b0;
						ev[EV_QUAL_A + r] = 1'b1;
					end
					else
						next_cnt[r] = cnt[r] - CNT_W'(1);
				default: next_qst[r] = Q_OK;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			qst[0] <= Q_OK;
			qst[1] <= Q_OK;
			cnt[0] <= '0;
			cnt[1] <= '0;
			soak_flag <= '0;
		end
		else
		begin
			qst <= next_qst;
			cnt <= next_cnt;
			soak_flag <= next_soak_flag;
		end
	end

	// a reference stays qualified until its disqualify delay has run out
	function automatic logic is_qual(input riqc_qstate_t s);
		is_qual = (s == Q_OK) || (s == Q_DISQ_WAIT);
	endfunction

	// configuration outputs from flip-flops; one process drives the whole struct
	assign pll_ref_clk = ref_out;
	always_comb
	begin
		cfg_out.halving_enable = {setup[SETUP_HALF_B], setup[SETUP_HALF_A]};
		cfg_out.differential_select = {setup[SETUP_DIFF_B], setup[SETUP_DIFF_A]};
		cfg_out.qualified[0] = is_qual(qst[0]);
		cfg_out.qualified[1] = is_qual(qst[1]);
		cfg_out.soak_expired_flag = soak_flag;
		cfg_out.freeze = (freeze == FREEZE_ON);
		cfg_out.base_rate_value = rate;
	end
endmodule

// ==== bench/riqc_properties.sv ====
/*
 checker for riqc_config: bus wait state, register to cfg_out paths, qualify state.
 assumes a bind onto riqc_config and a single core_clk domain.
*/
`timescale 1ns/1ps
module riqc_checker
	import riqc_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [1:0] ref_positive_pin,
	input wire logic [1:0] ref_negative_pin,
	input wire riqc_pkg::riqc_mon_t mon_in,
	input wire logic [1:0] pll_ref_clk,
	input wire riqc_pkg::riqc_cfg_t cfg_out,
	input wire logic irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	logic wr_done;
	logic [7:0] widx;
	logic [7:0] wd_q;
	logic [7:0] next_wd_q;
	// written byte kept, the master releases data right after acceptance
	assign wr_done = avs_write && !avs_waitrequest;
	assign widx = avs_address[9:2];
	always_comb
	begin
		next_wd_q = wr_done ? avs_writedata[7:0] : wd_q;
	end
	always_ff @(posedge core_clk)
	begin
		wd_q <= next_wd_q;
	end

	AST_ONE_WAIT: assert property ($rose(avs_read || avs_write) |->
		avs_waitrequest ##1 !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	AST_SETUP_MAP: assert property (wr_done && widx == IDX_SETUP |=> ##1
		cfg_out.halving_enable == wd_q[1:0] && cfg_out.differential_select == wd_q[5:4])
		else $error("setup fields not applied");
	AST_FREEZE_MAP: assert property (wr_done && widx == IDX_FREEZE |=> ##1
		cfg_out.freeze == (wd_q == FREEZE_ON))
		else $error("freeze level wrong");
	AST_RATE_HI: assert property (wr_done && widx == IDX_RATE_HI |=> ##1
		cfg_out.base_rate_value[15:8] == wd_q)
		else $error("rate high byte wrong");
	AST_RATE_LO: assert property (wr_done && widx == IDX_RATE_LO |=> ##1
		cfg_out.base_rate_value[7:0] == wd_q)
		else $error("rate low byte wrong");
	AST_RESET_VAL: assert property ($fell(reset) |->
		cfg_out.base_rate_value == RST_RATE && cfg_out.differential_select == RST_SETUP[5:4] &&
		cfg_out.halving_enable == 2'h0 && !irq)
		else $error("reset values wrong");
	// three input flops and the filtered level put the indicators four and five samples back
	AST_DISQ_CAUSE: assert property ($fell(cfg_out.qualified[0]) |->
		$past(mon_in.fail_cfm[0], 4) || $past(mon_in.fail_cfm[0], 5) ||
		$past(mon_in.fail_scm[0], 4) || $past(mon_in.fail_scm[0], 5))
		else $error("disqualified without indicator");
	AST_QUAL_CAUSE: assert property ($rose(cfg_out.qualified[0]) |->
		!($past(mon_in.fail_cfm[0], 4) && $past(mon_in.fail_cfm[0], 5)) &&
		!($past(mon_in.fail_scm[0], 4) && $past(mon_in.fail_scm[0], 5)))
		else $error("qualified while indicator present");
	AST_SOAK_DISQ: assert property ($rose(cfg_out.soak_expired_flag[0]) |->
		##[0:2] !cfg_out.qualified[0])
		else $error("soak flag without disqualify");
endmodule

bind riqc_config riqc_checker chk_i (.core_clk(core_clk), .reset(reset),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .ref_positive_pin(ref_positive_pin),
	.ref_negative_pin(ref_negative_pin), .mon_in(mon_in), .pll_ref_clk(pll_ref_clk),
	.cfg_out(cfg_out), .irq(irq));

// ==== bench/testbench.sv ====
/*
 testbench for riqc_config: register tasks, reference pins, monitor indicators.
 assumes the checker is bound from its own file.
*/
`timescale 1ns/1ps
module testbench;
	import riqc_pkg::*;
	logic core_clk;
	logic reset;
	logic [9:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [1:0] ref_positive_pin = 2'h0;
	logic [1:0] ref_negative_pin = 2'h0;
	riqc_mon_t mon_in;
	logic [1:0] pll_ref_clk;
	riqc_cfg_t cfg_out;
	logic irq;
	int n_errors;
	int total_checks;
	int cyc = 0;
	int d;
	int d0;
	logic [2:0] ph = 3'h0;
	logic [1:0] nmode;
	logic [31:0] q;
	logic [7:0] ri [8];
	logic [7:0] rv [8];
	logic [15:0] rt [9];
	int md [4];

	riqc_config dut (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.ref_positive_pin(ref_positive_pin), .ref_negative_pin(ref_negative_pin),
		.mon_in(mon_in), .pll_ref_clk(pll_ref_clk), .cfg_out(cfg_out), .irq(irq));

	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// pins run free at eight cycles a period; nmode 0 ground, 1 inverse, 2 equal
	always @(posedge core_clk)
	begin
		ph <= ph + 3'h1;
		ref_positive_pin <= {2{ph[2]}};
		ref_negative_pin <= (nmode == 2'h1) ? {2{~ph[2]}} : (nmode == 2'h2) ? {2{ph[2]}} : 2'h0;
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_errors++;
			test_done();
		end
	end

	task test_done;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask

	// one transfer; entered just after an edge, leaves one idle cycle
	task bus(input logic rd, input logic [7:0] idx, input logic [7:0] wd);
		avs_address <= {idx, 2'b00};
		avs_read <= rd;
		avs_write <= !rd;
		avs_writedata <= {24'h0, wd};
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge core_clk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask

	task rc(input logic [7:0] idx, input logic [7:0] e);
		bus(1'b1, idx, 8'h00);
		chk($sformatf("reg %h", idx), {24'h0, e}, q);
	endtask

	// counts loop clock rises; window edges allow one off
	task rises(input int ea, input int eb);
		int a;
		int b;
		logic [1:0] pv;
		a = 0;
		b = 0;
		repeat (8) @(posedge core_clk);
		pv = pll_ref_clk;
		repeat (128)
		begin
			@(posedge core_clk);
			a += int'(pll_ref_clk[0] === 1'b1 && pv[0] === 1'b0);
			b += int'(pll_ref_clk[1] === 1'b1 && pv[1] === 1'b0);
			pv = pll_ref_clk;
		end
		chk("rises a", 32'h1, 32'(a >= ea - 1 && a <= ea + 1));
		chk("rises b", 32'h1, 32'(b >= eb - 1 && b <= eb + 1));
	endtask

	task wq(input int r);
		d = 0;
		while (cfg_out.qualified[r] !== 1'b1 && d < 200)
		begin
			@(posedge core_clk);
			d++;
		end
	endtask

	// disqualify ref a, then time the requalification
	task qrun(input logic [1:0] c, input logic s);
		bus(1'b0, IDX_QUAL, {4'h0, c, c});
		mon_in.fail_scm[0] <= s;
		mon_in.fail_cfm[0] <= !s;
		repeat (20) @(posedge core_clk);
		chk("qualified a", 32'h0, 32'(cfg_out.qualified[0]));
		chk("irq", 32'h1, 32'(irq));
		mon_in <= '0;
		wq(0);
		rc(IDX_IRQ_STAT, 8'h05);
		chk("irq", 32'h0, 32'(irq));
	endtask

	initial
	begin
		reset = 1'b1;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		mon_in = '0;
		nmode = 2'h0;
		n_errors = 0;
		total_checks = 0;
		ri = '{IDX_SETUP, IDX_DISQ, IDX_QUAL, IDX_FREEZE, IDX_RATE_HI, IDX_RATE_LO,
			IDX_IRQ_STAT, IDX_IRQ_MASK};
		rv = '{RST_SETUP, RST_DISQ, RST_QUAL, RST_FREEZE, RST_RATE[15:8], RST_RATE[7:0],
			8'h00, 8'h00};
		rt = '{16'h03e8, 16'h07d0, 16'h1388, 16'h186a, 16'h1f40, 16'h2710, 16'h30d4,
			16'h61a8, 16'h9c40};
		md = '{2, 4, 6, 8};
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		foreach (ri[i]) rc(ri[i], rv[i]);
		// reserved bits keep reset values, unmapped place reads zero
		bus(1'b0, IDX_SETUP, 8'hff);
		rc(IDX_SETUP, 8'h33);
		bus(1'b0, IDX_DISQ, 8'h00);
		rc(IDX_DISQ, 8'ha0);
		bus(1'b0, 8'h30, 8'hff);
		rc(8'h30, 8'h00);
		// halving and input selection on both references
		bus(1'b0, IDX_SETUP, 8'h00);
		rises(16, 16);
		bus(1'b0, IDX_SETUP, 8'h03);
		rises(8, 8);
		// halved 40 khz reference: software programs its base rate as 20 khz
		bus(1'b0, IDX_RATE_HI, 8'h4e);
		bus(1'b0, IDX_RATE_LO, 8'h20);
		chk("half rate", 32'h00004e20, {16'h0, cfg_out.base_rate_value});
		bus(1'b0, IDX_SETUP, 8'h30);
		nmode <= 2'h1;
		rises(16, 16);
		nmode <= 2'h2;
		rises(0, 0);
		bus(1'b0, IDX_SETUP, 8'h00);
		rises(16, 16);
		nmode <= 2'h0;
		foreach (rt[i])
		begin
			bus(1'b0, IDX_RATE_HI, rt[i][15:8]);
			bus(1'b0, IDX_RATE_LO, rt[i][7:0]);
			rc(IDX_RATE_HI, rt[i][15:8]);
			chk("rate", {16'h0, rt[i]}, {16'h0, cfg_out.base_rate_value});
		end
		// qualify multiples measured against code 00, minimum delay one cycle
		bus(1'b0, IDX_IRQ_MASK, 8'h0f);
		qrun(2'h0, 1'b0);
		d0 = d;
		for (int c = 1; c < 4; c++)
		begin
			qrun(c[1:0], c[0]);
			chk("qual delay", 32'(md[c] - md[0]), 32'(d - d0));
		end
		// one indicator still present must hold the reference off
		mon_in <= 4'h5;
		repeat (20) @(posedge core_clk);
		mon_in.fail_cfm[0] <= 1'b0;
		repeat (30) @(posedge core_clk);
		chk("qualified a", 32'h0, 32'(cfg_out.qualified[0]));
		rc(IDX_QSTATE, 8'h31);
		mon_in <= '0;
		wq(0);
		rc(IDX_IRQ_STAT, 8'h05);
		// frozen: no events reach status; then masked events set status only
		bus(1'b0, IDX_IRQ_MASK, 8'h00);
		bus(1'b0, IDX_FREEZE, FREEZE_ON);
		rc(IDX_FREEZE, FREEZE_ON);
		for (int f = 0; f < 2; f++)
		begin
			mon_in.fail_cfm[1] <= 1'b1;
			repeat (20) @(posedge core_clk);
			chk("qualified b", 32'h0, 32'(cfg_out.qualified[1]));
			chk("irq", 32'h0, 32'(irq));
			mon_in <= '0;
			wq(1);
			rc(IDX_IRQ_STAT, (f == 0) ? 8'h00 : 8'h0a);
			bus(1'b0, IDX_FREEZE, FREEZE_OFF);
		end
		rc(IDX_IRQ_STAT, 8'h00);
		test_done();
	end
endmodule
